// ===== rtl/idf_pkg.sv
// Constants, types and helpers shared by the dispatch fault checker.
// Assumes one clock domain; all users import idf_pkg::*.
package idf_pkg;

	// ------------------------------------------------------------
	// Register map (APB byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ERRCODE = 8'h08;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RESET = 1'b1;
	localparam int STAT_CLASS_LSB = 0;
	localparam int STAT_COUNT_LSB = 8;

	// ------------------------------------------------------------
	// Flags register bit positions
	// ------------------------------------------------------------
	localparam int FL_TRAP = 8;
	localparam int FL_IF = 9;
	localparam int FL_OVF = 11;
	localparam int FL_NEST = 14;
	localparam int FL_RESUME = 16;
	localparam int FL_VIRT = 17;
	localparam int FL_ALIGN = 18;

	// ------------------------------------------------------------
	// Descriptor and selector layout
	// ------------------------------------------------------------
	localparam logic [3:0] DT_TASK = 4'h5;
	localparam logic [3:0] DT_INTR16 = 4'h6;
	localparam logic [3:0] DT_TRAP16 = 4'h7;
	localparam logic [3:0] DT_INTR32 = 4'he;
	localparam logic [3:0] DT_TRAP32 = 4'hf;
	localparam int DT_SIZE_BIT = 3;
	localparam int SEL_TI_BIT = 2;
	localparam logic [1:0] PRIV_USER = 2'h3;
	localparam logic [2:0] IVT_PROT_LAST = 3'h7;
	localparam logic [1:0] IVT_REAL_LAST = 2'h3;

	// ------------------------------------------------------------
	// Stack room needed, in bytes
	// ------------------------------------------------------------
	localparam logic [5:0] NEED_INTER32_EC = 6'h18;
	localparam logic [5:0] NEED_INTER32 = 6'h14;
	localparam logic [5:0] NEED_INTER16_EC = 6'h0c;
	localparam logic [5:0] NEED_INTER16 = 6'h0a;
	localparam logic [5:0] NEED_V86_32_EC = 6'h28;
	localparam logic [5:0] NEED_V86_32 = 6'h24;
	localparam logic [5:0] NEED_V86_16_EC = 6'h14;
	localparam logic [5:0] NEED_V86_16 = 6'h12;
	localparam logic [5:0] NEED_INTRA32_EC = 6'h10;
	localparam logic [5:0] NEED_INTRA32 = 6'h0c;
	localparam logic [5:0] NEED_INTRA16_EC = 6'h08;
	localparam logic [5:0] NEED_INTRA16 = 6'h06;
	localparam logic [5:0] NEED_REAL = 6'h06;

	typedef enum logic [1:0] {
		MODE_REAL = 2'b00,
		MODE_PROT = 2'b01,
		MODE_V86 = 2'b10
	} idf_mode_t;

	typedef enum logic [1:0] {
		SRC_EXT = 2'b00,
		SRC_SWINT = 2'b01,
		SRC_BRK = 2'b10,
		SRC_OVCHK = 2'b11
	} idf_src_t;

	typedef enum logic [2:0] {
		FC_NONE = 3'b000,
		FC_GP = 3'b001,
		FC_SS = 3'b010,
		FC_NP = 3'b011,
		FC_TS = 3'b100,
		FC_PF = 3'b101,
		FC_BP = 3'b110,
		FC_OF = 3'b111
	} idf_fault_t;

	// Error code naming a descriptor table selector
	function automatic logic [15:0] sel_code(input logic [15:0] sel, input logic ext);
		sel_code = {sel[15:2], 1'b0, ext};
	endfunction

	// Error code naming a vector table entry
	function automatic logic [15:0] ivt_code(input logic [7:0] vec, input logic ext);
		ivt_code = {5'h00, vec, 2'b01, ext};
	endfunction

	function automatic logic sel_null(input logic [15:0] sel);
		sel_null = (sel[15:2] == 14'h0000);
	endfunction

endpackage

// ===== rtl/idf_chk_if.sv
// Carrier between the fault checker and its stack-room and flag helpers.
// Assumes all three sit on the same clock; signals are combinational.
interface idf_chk_if;
	import idf_pkg::*;
	idf_mode_t mode;
	logic gate32;
	logic err_push;
	logic stack_switch;
	logic intr_gate;
	logic [15:0] room;
	logic [31:0] flags_in;
	logic [5:0] need;
	logic room_ok;
	logic [31:0] flags_new;

	modport ctl (output mode, gate32, err_push, stack_switch, intr_gate, room, flags_in,
		input need, room_ok, flags_new);
	modport rm (input mode, gate32, err_push, stack_switch, room, output need, room_ok);
	modport flg (input mode, intr_gate, flags_in, output flags_new);
endinterface

// ===== rtl/idf_stack_room.sv
// Stack room check: bytes a dispatch pushes versus bytes available.
// Assumes the caller picks the new or the current stack's room.
module idf_stack_room
	import idf_pkg::*;
(
	idf_chk_if.rm chk
);

	always_comb begin
		if (chk.mode == MODE_REAL)
			chk.need = NEED_REAL;
		else if (chk.mode == MODE_V86)
			chk.need = chk.gate32 ? (chk.err_push ? NEED_V86_32_EC : NEED_V86_32)
				: (chk.err_push ? NEED_V86_16_EC : NEED_V86_16);
		else if (chk.stack_switch)
			chk.need = chk.gate32 ? (chk.err_push ? NEED_INTER32_EC : NEED_INTER32)
				: (chk.err_push ? NEED_INTER16_EC : NEED_INTER16);
		else
			chk.need = chk.gate32 ? (chk.err_push ? NEED_INTRA32_EC : NEED_INTRA32)
				: (chk.err_push ? NEED_INTRA16_EC : NEED_INTRA16);
	end

	assign chk.room_ok = (chk.room >= {10'h000, chk.need});

endmodule

// ===== rtl/idf_flag_image.sv
// Flags as they stand once a dispatch commits.
// Assumes the pushed image is the incoming flags, unchanged.
module idf_flag_image
	import idf_pkg::*;
(
	idf_chk_if.flg chk
);

	always_comb begin
		chk.flags_new = chk.flags_in;
		chk.flags_new[FL_TRAP] = 1'b0;
		chk.flags_new[FL_ALIGN] = 1'b0;
		if (chk.mode == MODE_REAL) begin
			chk.flags_new[FL_IF] = 1'b0;
		end else begin
			chk.flags_new[FL_NEST] = 1'b0;
			chk.flags_new[FL_RESUME] = 1'b0;
			chk.flags_new[FL_VIRT] = 1'b0;
			// Trap gates leave interrupts enabled
			if (chk.intr_gate)
				chk.flags_new[FL_IF] = 1'b0;
		end
	end

endmodule

// ===== rtl/idf_dispatch_check.sv
// Interrupt dispatch fault checker with an APB register slave.
// Assumes descriptor fields are fetched by the core and held with REQ_VALID.
//
// Decided for this implementation: the APB slave port and the address map.
module idf_dispatch_check
	import idf_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic NRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Dispatch request
	input wire logic REQ_VALID,
	input wire logic [1:0] MODE,
	input wire logic [1:0] SOURCE,
	input wire logic EXT_EVENT,
	input wire logic [7:0] VECTOR,
	input wire logic [15:0] IVT_LIMIT,
	input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL,
	input wire logic [1:0] IO_PRIVILEGE_LEVEL,
	input wire logic [31:0] FLAGS_IN,
	input wire logic ERR_PUSH,
	input wire logic PAGE_FAULT,
	input wire logic [15:0] PAGE_FAULT_CODE,
	input wire logic MEM_OPERAND_OUT,
	// Gate from the vector table
	input wire logic [3:0] GATE_TYPE,
	input wire logic GATE_PRESENT,
	input wire logic [1:0] GATE_PRIV,
	input wire logic [15:0] GATE_SELECTOR,
	input wire logic [31:0] TARGET_IP,
	// Descriptor named by the gate: code segment or task state segment
	input wire logic TGT_IN_LIMIT,
	input wire logic TGT_IS_CODE,
	input wire logic TGT_CONFORMING,
	input wire logic TGT_PRESENT,
	input wire logic [1:0] TGT_PRIV,
	input wire logic [31:0] TGT_LIMIT,
	input wire logic TASK_SEG_BUSY,
	// New stack from the task state segment, and stack room
	input wire logic [15:0] NEW_SS_SELECTOR,
	input wire logic NEW_SS_IN_LIMIT,
	input wire logic NEW_SS_WRITABLE,
	input wire logic [1:0] NEW_SS_PRIV,
	input wire logic NEW_SS_PRESENT,
	input wire logic [15:0] NEW_STACK_ROOM,
	input wire logic [15:0] CUR_STACK_ROOM,
	// Result
	output logic DONE,
	output logic [2:0] FAULT_CLASS,
	output logic [15:0] ERROR_CODE,
	output logic COMMIT,
	output logic STACK_SWITCH,
	output logic [31:0] PUSH_FLAGS,
	output logic [31:0] NEW_FLAGS
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	idf_chk_if chk ();
	idf_mode_t mode;
	idf_fault_t next_class;
	logic [15:0] next_code;
	logic ctrl_en;
	logic [7:0] fault_count;
	logic take, dispatching, is_task, is_intr, type_ok, sw_int, ivt_over, ip_over, sw;

	assign mode = idf_mode_t'(MODE);
	assign take = REQ_VALID && ctrl_en;
	assign sw_int = (SOURCE == SRC_SWINT);
	assign dispatching = (SOURCE == SRC_EXT) || sw_int;
	assign is_task = (GATE_TYPE == DT_TASK);
	assign is_intr = (GATE_TYPE == DT_INTR16) || (GATE_TYPE == DT_INTR32);
	assign type_ok = is_task || is_intr || (GATE_TYPE == DT_TRAP16) || (GATE_TYPE == DT_TRAP32);
	assign ip_over = (TARGET_IP > TGT_LIMIT);
	// Real mode entries are four bytes, protected and virtual entries eight
	assign ivt_over = (mode == MODE_REAL) ? ({6'h00, VECTOR, IVT_REAL_LAST} > IVT_LIMIT)
		: ({5'h00, VECTOR, IVT_PROT_LAST} > IVT_LIMIT);
	assign sw = (mode != MODE_REAL) && !is_task && !TGT_CONFORMING && (TGT_PRIV < CURRENT_PRIVILEGE_LEVEL);

	assign chk.mode = mode;
	assign chk.gate32 = GATE_TYPE[DT_SIZE_BIT];
	assign chk.err_push = ERR_PUSH;
	assign chk.stack_switch = sw;
	assign chk.intr_gate = is_intr;
	assign chk.room = sw ? NEW_STACK_ROOM : CUR_STACK_ROOM;
	assign chk.flags_in = FLAGS_IN;

	idf_stack_room u_room (
		.chk(chk)
	);

	idf_flag_image u_flags (
		.chk(chk)
	);

	// ------------------------------------------------------------
	// Fault priority: the first check that fails wins
	// ------------------------------------------------------------
	always_comb begin
		next_class = FC_NONE;
		next_code = 16'h0000;
		if (PAGE_FAULT) begin
			next_class = FC_PF;
			next_code = PAGE_FAULT_CODE;
		end else if (SOURCE == SRC_BRK) begin
			next_class = FC_BP;
		end else if (SOURCE == SRC_OVCHK) begin
			// Overflow check with the flag clear simply falls through
			next_class = FLAGS_IN[FL_OVF] ? FC_OF : FC_NONE;
		end else if (mode == MODE_REAL) begin
			if (ivt_over) begin
				next_class = FC_GP;
				next_code = ivt_code(VECTOR, EXT_EVENT);
			end else if (MEM_OPERAND_OUT)
				next_class = FC_GP;
			else if (!chk.room_ok)
				next_class = FC_SS;
		end else if (ivt_over) begin
			next_class = FC_GP;
			next_code = ivt_code(VECTOR, EXT_EVENT);
		end else if (mode == MODE_V86 && sw_int && IO_PRIVILEGE_LEVEL < PRIV_USER && GATE_PRIV != PRIV_USER) begin
			next_class = FC_GP;
		end else if (!type_ok) begin
			next_class = FC_GP;
			next_code = ivt_code(VECTOR, EXT_EVENT);
		end else if (sw_int && GATE_PRIV < CURRENT_PRIVILEGE_LEVEL) begin
			next_class = FC_GP;
			next_code = ivt_code(VECTOR, EXT_EVENT);
		end else if (!GATE_PRESENT) begin
			next_class = FC_NP;
			next_code = ivt_code(VECTOR, EXT_EVENT);
		end else if (sel_null(GATE_SELECTOR)) begin
			next_class = FC_GP;
			next_code = sel_code(GATE_SELECTOR, EXT_EVENT);
		end else if (is_task && GATE_SELECTOR[SEL_TI_BIT]) begin
			next_class = FC_GP;
			next_code = sel_code(GATE_SELECTOR, EXT_EVENT);
		end else if (!TGT_IN_LIMIT) begin
			next_class = FC_GP;
			next_code = sel_code(GATE_SELECTOR, EXT_EVENT);
		end else if (is_task && TASK_SEG_BUSY) begin
			next_class = FC_GP;
			next_code = sel_code(GATE_SELECTOR, EXT_EVENT);
		end else if (!is_task && !TGT_IS_CODE) begin
			next_class = FC_GP;
			next_code = sel_code(GATE_SELECTOR, EXT_EVENT);
		end else if (!TGT_PRESENT) begin
			next_class = FC_NP;
			next_code = sel_code(GATE_SELECTOR, EXT_EVENT);
		end else if (sw && sel_null(NEW_SS_SELECTOR)) begin
			next_class = FC_TS;
			next_code = {15'h0000, EXT_EVENT};
		end else if (sw && (!NEW_SS_IN_LIMIT || NEW_SS_SELECTOR[1:0] != TGT_PRIV)) begin
			next_class = FC_TS;
			next_code = sel_code(NEW_SS_SELECTOR, EXT_EVENT);
		end else if (sw && (NEW_SS_PRIV != TGT_PRIV || !NEW_SS_WRITABLE)) begin
			next_class = FC_TS;
			next_code = sel_code(NEW_SS_SELECTOR, EXT_EVENT);
		end else if (sw && !NEW_SS_PRESENT) begin
			next_class = FC_SS;
			next_code = sel_code(NEW_SS_SELECTOR, EXT_EVENT);
		end else if (sw && !chk.room_ok) begin
			next_class = FC_SS;
			next_code = sel_code(NEW_SS_SELECTOR, EXT_EVENT);
		end else if (!sw && !is_task && !chk.room_ok) begin
			next_class = FC_SS;
		end else if (ip_over) begin
			next_class = FC_GP;
		end
	end

	// ------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			DONE <= 1'b0;
			FAULT_CLASS <= FC_NONE;
			ERROR_CODE <= 16'h0000;
			COMMIT <= 1'b0;
			STACK_SWITCH <= 1'b0;
			PUSH_FLAGS <= 32'h0000_0000;
			NEW_FLAGS <= 32'h0000_0000;
		end else begin
			DONE <= take;
			if (take) begin
				FAULT_CLASS <= next_class;
				ERROR_CODE <= next_code;
				COMMIT <= dispatching && next_class == FC_NONE;
				STACK_SWITCH <= dispatching && next_class == FC_NONE && sw;
				PUSH_FLAGS <= FLAGS_IN;
				// A faulting attempt hands back the flags untouched
				NEW_FLAGS <= (dispatching && next_class == FC_NONE) ? chk.flags_new : FLAGS_IN;
			end
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST)
			fault_count <= 8'h00;
		else if (take && next_class != FC_NONE)
			fault_count <= fault_count + 8'h01;
	end

	// ------------------------------------------------------------
	// APB slave: one wait state, so read data can come from flops
	// ------------------------------------------------------------
	logic apb_done;
	logic addr_ok;
	assign apb_done = PSEL && PENABLE && PREADY;
	assign addr_ok = (PADDR == REG_CTRL) || (PADDR == REG_STATUS) || (PADDR == REG_ERRCODE);

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= PSEL && PENABLE && !PREADY;
			PSLVERR <= PSEL && PENABLE && !PREADY && !addr_ok;
			if (PSEL && PENABLE && !PREADY && !PWRITE) begin
				case (PADDR)
					REG_CTRL: PRDATA <= {31'h0000_0000, ctrl_en};
					REG_STATUS: PRDATA <= {16'h0000, fault_count, 5'h00, FAULT_CLASS};
					REG_ERRCODE: PRDATA <= {16'h0000, ERROR_CODE};
					default: PRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST)
			ctrl_en <= CTRL_EN_RESET;
		else if (apb_done && PWRITE && PADDR == REG_CTRL)
			ctrl_en <= PWDATA[CTRL_EN_BIT];
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_done_follows_take: assert property (@(posedge MCLK) disable iff (!NRST)
		take |=> DONE ##1 !DONE || $past(take))
		else $error("DONE did not follow an accepted request");

	a_fault_no_state: assert property (@(posedge MCLK) disable iff (!NRST)
		DONE && FAULT_CLASS != FC_NONE |-> !COMMIT && NEW_FLAGS == $past(FLAGS_IN))
		else $error("Faulting dispatch altered state");

	a_ivt_limit_gp: assert property (@(posedge MCLK) disable iff (!NRST)
		take && dispatching && !PAGE_FAULT && ivt_over |=> FAULT_CLASS == FC_GP && ERROR_CODE[1])
		else $error("Vector beyond table limit not faulted");

	a_commit_ip_ok: assert property (@(posedge MCLK) disable iff (!NRST)
		DONE && COMMIT |-> $past(mode) == MODE_REAL || $past(TARGET_IP) <= $past(TGT_LIMIT))
		else $error("Dispatch committed beyond code limit");

	a_v86_io_priv: assert property (@(posedge MCLK) disable iff (!NRST)
		take && !PAGE_FAULT && sw_int && mode == MODE_V86 && !ivt_over
		&& IO_PRIVILEGE_LEVEL != PRIV_USER && GATE_PRIV != PRIV_USER
		|=> FAULT_CLASS == FC_GP && ERROR_CODE == 16'h0000)
		else $error("Virtual mode privilege check missed");

	a_commit_clears_tf: assert property (@(posedge MCLK) disable iff (!NRST)
		DONE && COMMIT |-> !NEW_FLAGS[FL_TRAP] && PUSH_FLAGS == $past(FLAGS_IN))
		else $error("Committed flags wrong");

	a_switch_room: assert property (@(posedge MCLK) disable iff (!NRST)
		take && sw && chk.gate32 && mode == MODE_PROT |-> chk.need == (ERR_PUSH ? NEED_INTER32_EC : NEED_INTER32))
		else $error("Wrong stack room for switch");

	a_brk_exception: assert property (@(posedge MCLK) disable iff (!NRST)
		take && !PAGE_FAULT && SOURCE == SRC_BRK |=> FAULT_CLASS == FC_BP && !COMMIT)
		else $error("Breakpoint exception not raised");

	a_apb_one_wait: assert property (@(posedge MCLK) disable iff (!NRST)
		PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
		else $error("APB ready timing broken");

endmodule

// ===== dv/idf_dispatch_check_tb_top.sv
// Self-checking bench for the interrupt dispatch fault checker.
// Assumes the checker's own assertions sit in its body; the bench drives every port itself.
module idf_dispatch_check_tb_top import idf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	localparam logic [31:0] FLAGS = 32'h0007_4b02;
	// Vector table entry code for vector 10h, internal event
	localparam logic [15:0] IVC = 16'h0082;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic req_valid = 1'b0;
	logic ext_event, err_push, page_fault, mem_out, gate_present, tgt_in_limit, tgt_is_code, tgt_conf;
	logic tgt_present, seg_busy, ss_in_limit, ss_writable, ss_present;
	logic [1:0] mode, source, cur_priv, io_priv, gate_priv, tgt_priv, ss_priv;
	logic [3:0] gate_type;
	logic [7:0] vector;
	logic [15:0] ivt_limit, pf_code, gate_sel, ss_sel, new_room, cur_room;
	logic [31:0] flags_in, target_ip, tgt_limit;
	logic done, commit, stack_switch;
	logic [2:0] fault_class;
	logic [15:0] error_code;
	logic [31:0] push_flags, new_flags;
	logic [3:0] gtab [4] = '{DT_INTR16, DT_TRAP16, DT_INTR32, DT_TRAP32};
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int faults = 0;

	idf_dispatch_check i_idf_dispatch_check (
		.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .REQ_VALID(req_valid),
		.MODE(mode), .SOURCE(source), .EXT_EVENT(ext_event), .VECTOR(vector), .IVT_LIMIT(ivt_limit),
		.CURRENT_PRIVILEGE_LEVEL(cur_priv), .IO_PRIVILEGE_LEVEL(io_priv), .FLAGS_IN(flags_in), .ERR_PUSH(err_push),
		.PAGE_FAULT(page_fault), .PAGE_FAULT_CODE(pf_code), .MEM_OPERAND_OUT(mem_out),
		.GATE_TYPE(gate_type), .GATE_PRESENT(gate_present), .GATE_PRIV(gate_priv), .GATE_SELECTOR(gate_sel),
		.TARGET_IP(target_ip), .TGT_IN_LIMIT(tgt_in_limit), .TGT_IS_CODE(tgt_is_code),
		.TGT_CONFORMING(tgt_conf), .TGT_PRESENT(tgt_present), .TGT_PRIV(tgt_priv), .TGT_LIMIT(tgt_limit),
		.TASK_SEG_BUSY(seg_busy), .NEW_SS_SELECTOR(ss_sel), .NEW_SS_IN_LIMIT(ss_in_limit),
		.NEW_SS_WRITABLE(ss_writable), .NEW_SS_PRIV(ss_priv), .NEW_SS_PRESENT(ss_present),
		.NEW_STACK_ROOM(new_room), .CUR_STACK_ROOM(cur_room), .DONE(done), .FAULT_CLASS(fault_class),
		.ERROR_CODE(error_code), .COMMIT(commit), .STACK_SWITCH(stack_switch), .PUSH_FLAGS(push_flags),
		.NEW_FLAGS(new_flags)
	);

	always #5 mclk = ~mclk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// A clean protected-mode dispatch through a 32-bit interrupt gate with a stack switch
	task automatic defaults();
		mode <= MODE_PROT;
		source <= SRC_EXT;
		ext_event <= 1'b0;
		vector <= 8'h10;
		ivt_limit <= 16'h07ff;
		cur_priv <= 2'h3;
		io_priv <= 2'h3;
		flags_in <= FLAGS;
		err_push <= 1'b0;
		page_fault <= 1'b0;
		pf_code <= 16'h0006;
		mem_out <= 1'b0;
		gate_type <= DT_INTR32;
		gate_present <= 1'b1;
		gate_priv <= 2'h3;
		gate_sel <= 16'h0010;
		target_ip <= 32'h0000_0100;
		tgt_in_limit <= 1'b1;
		tgt_is_code <= 1'b1;
		tgt_conf <= 1'b0;
		tgt_present <= 1'b1;
		tgt_priv <= 2'h0;
		tgt_limit <= 32'h0000_ffff;
		seg_busy <= 1'b0;
		ss_sel <= 16'h0018;
		ss_in_limit <= 1'b1;
		ss_writable <= 1'b1;
		ss_priv <= 2'h0;
		ss_present <= 1'b1;
		new_room <= 16'h0014;
		cur_room <= 16'h0100;
	endtask

	// Called at an edge; fields set at that edge ride with the request
	task automatic run(input idf_fault_t ec, input logic [15:0] code, input logic cc);
		req_valid <= 1'b1;
		@(posedge mclk);
		req_valid <= 1'b0;
		#1;
		chk("done", 32'h1, {31'h0, done});
		chk("class", {29'h0, ec}, {29'h0, fault_class});
		if (cc) begin
			chk("code", {16'h0, code}, {16'h0, error_code});
		end
		chk("commit", {31'h0, ec == FC_NONE && source != SRC_OVCHK}, {31'h0, commit});
		if (ec != FC_NONE) begin
			faults++;
			chk("fault_flags", flags_in, new_flags);
		end
		@(posedge mclk);
		defaults();
		@(posedge mclk);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv,
		output logic erv);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees ready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		defaults();
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h0, rd, err);
		chk("ctrl", 32'h1, rd);
		apb(1'b0, 8'h0c, 32'h0, rd, err);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, rd);
		run(FC_NONE, 16'h0000, 1'b0);
		chk("switch", 32'h1, {31'h0, stack_switch});
		chk("push_flags", FLAGS, push_flags);
		chk("new_flags", 32'h0000_0802, new_flags);
		new_room <= 16'h0013;
		run(FC_SS, 16'h0018, 1'b1);
		err_push <= 1'b1;
		new_room <= 16'h0018;
		run(FC_NONE, 16'h0000, 1'b0);
		err_push <= 1'b1;
		new_room <= 16'h0017;
		ext_event <= 1'b1;
		run(FC_SS, 16'h0019, 1'b1);
		// Trap gates leave interrupts enabled
		for (int i = 0; i < 4; i++) begin
			gate_type <= gtab[i];
			run(FC_NONE, 16'h0000, 1'b0);
			chk("gate_flags", gtab[i][0] ? 32'h0000_0a02 : 32'h0000_0802, new_flags);
		end
		gate_type <= 4'h1;
		run(FC_GP, IVC, 1'b1);
		target_ip <= 32'h0001_0000;
		run(FC_GP, 16'h0000, 1'b1);
		target_ip <= 32'h0000_ffff;
		run(FC_NONE, 16'h0000, 1'b0);
		gate_sel <= 16'h0003;
		ext_event <= 1'b1;
		run(FC_GP, 16'h0001, 1'b1);
		tgt_in_limit <= 1'b0;
		run(FC_GP, 16'h0010, 1'b1);
		ivt_limit <= 16'h0086;
		run(FC_GP, IVC, 1'b1);
		ivt_limit <= 16'h0087;
		run(FC_NONE, 16'h0000, 1'b0);
		source <= SRC_SWINT;
		gate_priv <= 2'h2;
		run(FC_GP, IVC, 1'b1);
		gate_priv <= 2'h2;
		run(FC_NONE, 16'h0000, 1'b0);
		tgt_is_code <= 1'b0;
		run(FC_GP, 16'h0010, 1'b1);
		gate_type <= DT_TASK;
		gate_sel <= 16'h0024;
		run(FC_GP, 16'h0024, 1'b1);
		gate_type <= DT_TASK;
		seg_busy <= 1'b1;
		run(FC_GP, 16'h0010, 1'b1);
		gate_type <= DT_TASK;
		run(FC_NONE, 16'h0000, 1'b0);
		gate_present <= 1'b0;
		run(FC_NP, IVC, 1'b1);
		tgt_present <= 1'b0;
		run(FC_NP, 16'h0010, 1'b1);
		ss_sel <= 16'h0000;
		ext_event <= 1'b1;
		run(FC_TS, 16'h0001, 1'b1);
		ss_sel <= 16'h0019;
		run(FC_TS, 16'h0018, 1'b1);
		ss_priv <= 2'h1;
		run(FC_TS, 16'h0018, 1'b1);
		ss_writable <= 1'b0;
		run(FC_TS, 16'h0018, 1'b1);
		ss_in_limit <= 1'b0;
		run(FC_TS, 16'h0018, 1'b1);
		ss_present <= 1'b0;
		run(FC_SS, 16'h0018, 1'b1);
		tgt_priv <= 2'h3;
		cur_room <= 16'h000c;
		run(FC_NONE, 16'h0000, 1'b0);
		chk("no_switch", 32'h0, {31'h0, stack_switch});
		tgt_priv <= 2'h3;
		cur_room <= 16'h000b;
		run(FC_SS, 16'h0000, 1'b1);
		mode <= MODE_V86;
		new_room <= 16'h0024;
		run(FC_NONE, 16'h0000, 1'b0);
		mode <= MODE_V86;
		new_room <= 16'h0023;
		run(FC_SS, 16'h0018, 1'b1);
		mode <= MODE_V86;
		source <= SRC_SWINT;
		io_priv <= 2'h2;
		gate_priv <= 2'h2;
		run(FC_GP, 16'h0000, 1'b1);
		mode <= MODE_V86;
		source <= SRC_SWINT;
		io_priv <= 2'h2;
		new_room <= 16'h0024;
		run(FC_NONE, 16'h0000, 1'b0);
		mode <= MODE_REAL;
		run(FC_NONE, 16'h0000, 1'b0);
		chk("real_flags", 32'h0003_4802, new_flags);
		mode <= MODE_REAL;
		cur_room <= 16'h0005;
		run(FC_SS, 16'h0000, 1'b0);
		mode <= MODE_REAL;
		mem_out <= 1'b1;
		run(FC_GP, 16'h0000, 1'b0);
		mode <= MODE_REAL;
		ivt_limit <= 16'h0042;
		run(FC_GP, 16'h0000, 1'b0);
		source <= SRC_BRK;
		run(FC_BP, 16'h0000, 1'b0);
		source <= SRC_OVCHK;
		run(FC_OF, 16'h0000, 1'b0);
		source <= SRC_OVCHK;
		flags_in <= FLAGS & ~(32'h1 << FL_OVF);
		run(FC_NONE, 16'h0000, 1'b0);
		page_fault <= 1'b1;
		gate_type <= 4'h1;
		run(FC_PF, 16'h0006, 1'b1);
		// Disabled checker ignores requests
		apb(1'b1, REG_CTRL, 32'h0, rd, err);
		req_valid <= 1'b1;
		@(posedge mclk);
		req_valid <= 1'b0;
		#1;
		chk("refused", 32'h0, {31'h0, done});
		apb(1'b1, REG_CTRL, 32'h1, rd, err);
		apb(1'b0, REG_STATUS, 32'h0, rd, err);
		chk("status", {16'h0, faults[7:0], 5'h00, FC_PF}, rd);
		apb(1'b0, REG_ERRCODE, 32'h0, rd, err);
		chk("errcode", 32'h0000_0006, rd);
		give_verdict();
	end
endmodule
